// *** rtl/erl_pkg.sv ***
// register map, reset values and carrier types for the electrode routing register bank
// ============================================================================
package erl_pkg;

    // ========================================================================
    // register indices; byte address is four times the index
    localparam int REG_W = 8;
    localparam logic [5:0] IDX_BIAS_POS = 6'h0D;
    localparam logic [5:0] IDX_BIAS_NEG = 6'h0E;
    localparam logic [5:0] IDX_LO_POS = 6'h0F;
    localparam logic [5:0] IDX_LO_NEG = 6'h10;
    localparam logic [5:0] IDX_POLARITY = 6'h11;
    localparam logic [5:0] IDX_STAT_POS = 6'h12;
    localparam logic [5:0] IDX_STAT_NEG = 6'h13;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================================
    // carrier for the configuration that leaves the bank
    typedef struct packed {
        logic [7:0] leadoff_current_polarity;
        logic [7:0] leadoff_negative_enable;
        logic [7:0] leadoff_positive_enable;
        logic [7:0] bias_negative_routing;
        logic [7:0] bias_positive_routing;
    } erl_cfg_t;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_BIAS_POS, SEL_BIAS_NEG, SEL_LO_POS,
        SEL_LO_NEG, SEL_POLARITY, SEL_STAT_POS, SEL_STAT_NEG
    } erl_sel_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h1,
        WR_RESP = 2'h2
    } erl_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_RESP = 2'h2
    } erl_rd_state_t;

    // ========================================================================
    // byte address to register select; low two address bits are ignored
    function automatic erl_sel_t erl_decode(input logic [7:0] addr);
        erl_sel_t sel;
        sel = SEL_NONE;
        unique case (addr[7:2])
            IDX_BIAS_POS: sel = SEL_BIAS_POS;
            IDX_BIAS_NEG: sel = SEL_BIAS_NEG;
            IDX_LO_POS: sel = SEL_LO_POS;
            IDX_LO_NEG: sel = SEL_LO_NEG;
            IDX_POLARITY: sel = SEL_POLARITY;
            IDX_STAT_POS: sel = SEL_STAT_POS;
            IDX_STAT_NEG: sel = SEL_STAT_NEG;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

endpackage

// *** rtl/erl_regs.sv ***
// axi4-lite register bank for electrode bias routing and lead-off detection control
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module erl_regs #(
    parameter int NUM_CHANNELS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] comp_pos_off,
    input wire logic [7:0] comp_neg_off,
    output erl_pkg::erl_cfg_t cfg_q
);

    // ========================================================================
    // channels that exist on this variant; the rest are forced to zero
    localparam logic [7:0] CHAN_MASK = 8'(16'h00FF >> (8 - NUM_CHANNELS));

    erl_pkg::erl_wr_state_t wr_state_q, wr_state_d;
    erl_pkg::erl_rd_state_t rd_state_q, rd_state_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb_q, wstrb_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    erl_pkg::erl_cfg_t cfg_d;
    logic [7:0] electrode_off_positive_flags_q, electrode_off_positive_flags_d;
    logic [7:0] electrode_off_negative_flags_q, electrode_off_negative_flags_d;
    logic wr_en;
    erl_pkg::erl_sel_t wr_sel, rd_sel;
    logic [7:0] wr_val;

    // ========================================================================
    // write channel: address and data collected in either order, then one response
    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        wr_en = 1'b0;
        wr_sel = erl_pkg::erl_decode(awaddr_q);
        unique case (wr_state_q)
            erl_pkg::WR_COLLECT: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_have_d = 1'b1;
                    awaddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_have_d = 1'b1;
                    wdata_d = s_axi_wdata[7:0];
                    wstrb_d = s_axi_wstrb[0];
                end
                // commit only from stored copies so both orders behave the same
                if (aw_have_q && w_have_q) begin
                    wr_en = 1'b1;
                    bvalid_d = 1'b1;
                    bresp_d = (wr_sel == erl_pkg::SEL_NONE) ? erl_pkg::RESP_SLVERR
                                                            : erl_pkg::RESP_OKAY;
                    wr_state_d = erl_pkg::WR_RESP;
                end
            end
            erl_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    wr_state_d = erl_pkg::WR_COLLECT;
                end
            end
        endcase
        awready_d = (wr_state_d == erl_pkg::WR_COLLECT) && !aw_have_d;
        wready_d = (wr_state_d == erl_pkg::WR_COLLECT) && !w_have_d;
    end

    // ========================================================================
    // bank registers; absent channel bits never store, so their effects stay off
    always_comb begin
        cfg_d = cfg_q;
        wr_val = wdata_q & CHAN_MASK;
        if (wr_en && wstrb_q) begin
            unique case (wr_sel)
                erl_pkg::SEL_BIAS_POS: cfg_d.bias_positive_routing = wr_val;
                erl_pkg::SEL_BIAS_NEG: cfg_d.bias_negative_routing = wr_val;
                erl_pkg::SEL_LO_POS: cfg_d.leadoff_positive_enable = wr_val;
                erl_pkg::SEL_LO_NEG: cfg_d.leadoff_negative_enable = wr_val;
                erl_pkg::SEL_POLARITY: cfg_d.leadoff_current_polarity = wr_val;
                default: cfg_d = cfg_q; // status is read-only, writes ignored
            endcase
        end
        // off flags follow the comparators: 1 means electrode off
        electrode_off_positive_flags_d = comp_pos_off & CHAN_MASK;
        electrode_off_negative_flags_d = comp_neg_off & CHAN_MASK;
    end

    // ========================================================================
    // read channel: data is captured at acceptance so it holds while rvalid waits
    always_comb begin
        rd_state_d = rd_state_q;
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        rd_sel = erl_pkg::erl_decode(s_axi_araddr);
        unique case (rd_state_q)
            erl_pkg::RD_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    rvalid_d = 1'b1;
                    rresp_d = erl_pkg::RESP_OKAY;
                    rdata_d = 32'h0000_0000; // upper bits read as zero
                    unique case (rd_sel)
                        erl_pkg::SEL_BIAS_POS: rdata_d[7:0] = cfg_q.bias_positive_routing;
                        erl_pkg::SEL_BIAS_NEG: rdata_d[7:0] = cfg_q.bias_negative_routing;
                        erl_pkg::SEL_LO_POS: rdata_d[7:0] = cfg_q.leadoff_positive_enable;
                        erl_pkg::SEL_LO_NEG: rdata_d[7:0] = cfg_q.leadoff_negative_enable;
                        erl_pkg::SEL_POLARITY: rdata_d[7:0] = cfg_q.leadoff_current_polarity;
                        erl_pkg::SEL_STAT_POS: rdata_d[7:0] = electrode_off_positive_flags_q;
                        erl_pkg::SEL_STAT_NEG: rdata_d[7:0] = electrode_off_negative_flags_q;
                        default: rresp_d = erl_pkg::RESP_SLVERR;
                    endcase
                    rd_state_d = erl_pkg::RD_RESP;
                end
            end
            erl_pkg::RD_RESP: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    rd_state_d = erl_pkg::RD_IDLE;
                end
            end
        endcase
        arready_d = (rd_state_d == erl_pkg::RD_IDLE);
    end

    // ========================================================================
    // state registers; ce low freezes everything, bus included
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= erl_pkg::WR_COLLECT;
            rd_state_q <= erl_pkg::RD_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= erl_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= erl_pkg::RESP_OKAY;
            cfg_q <= '0;
            electrode_off_positive_flags_q <= erl_pkg::RST_REG;
            electrode_off_negative_flags_q <= erl_pkg::RST_REG;
        end else if (ce) begin
            wr_state_q <= wr_state_d;
            rd_state_q <= rd_state_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            cfg_q <= cfg_d;
            electrode_off_positive_flags_q <= electrode_off_positive_flags_d;
            electrode_off_negative_flags_q <= electrode_off_negative_flags_d;
        end
    end

    // ========================================================================
    // checks on the bank
    logic wr_go;
    assign wr_go = ce && wr_en && wstrb_q;

    AST_NEG_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == erl_pkg::SEL_BIAS_NEG
        |=> cfg_q.bias_negative_routing == ($past(wdata_q) & CHAN_MASK))
        else $error("negative bias routing not written");
    AST_UPPER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_POS_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == erl_pkg::SEL_LO_POS
        |=> cfg_q.leadoff_positive_enable == ($past(wdata_q) & CHAN_MASK))
        else $error("positive lead-off enable not written");
    AST_NEG_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == erl_pkg::SEL_LO_NEG
        |=> cfg_q.leadoff_negative_enable == ($past(wdata_q) & CHAN_MASK))
        else $error("negative lead-off enable not written");
    AST_POLARITY: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == erl_pkg::SEL_POLARITY
        |=> cfg_q.leadoff_current_polarity == ($past(wdata_q) & CHAN_MASK))
        else $error("polarity not written");
    AST_POS_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_sel == erl_pkg::SEL_BIAS_POS
        |=> cfg_q.bias_positive_routing == ($past(wdata_q) & CHAN_MASK) ##1
        $stable(cfg_q.bias_positive_routing) || $past(wr_go))
        else $error("positive bias routing not written or not held");
    AST_OFF_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> electrode_off_positive_flags_q == ($past(comp_pos_off) & CHAN_MASK)
        && electrode_off_negative_flags_q == ($past(comp_neg_off) & CHAN_MASK))
        else $error("off flags do not follow comparators");
    AST_ABSENT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        ((cfg_q.bias_positive_routing | cfg_q.bias_negative_routing
        | cfg_q.leadoff_positive_enable | cfg_q.leadoff_negative_enable
        | cfg_q.leadoff_current_polarity) & ~CHAN_MASK) == 8'h00)
        else $error("absent channel bit is active");
    AST_BRESP_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && ce |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response late");
    // clock enable low must hold configuration, off flags and the write response still
    AST_CE_FREEZE: assert property (@(posedge aclk) disable iff (!aresetn)
        !ce |=> $stable(cfg_q) && $stable(electrode_off_positive_flags_q)
        && $stable(electrode_off_negative_flags_q) && $stable(s_axi_bvalid))
        else $error("state moved while clock enable was low");

    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready && s_axi_bresp == erl_pkg::RESP_OKAY);
    COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready && s_axi_rdata[7:0] != 8'h00);
    COV_BAD_ADDR: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == erl_pkg::RESP_SLVERR);
    COV_OFF_FLAG: cover property (@(posedge aclk) disable iff (!aresetn)
        electrode_off_negative_flags_q != 8'h00);

endmodule

// *** tb/erl_regs_tb.sv ***
// self-checking testbench for the electrode routing register bank over axi4-lite
`timescale 1ns/1ps
module erl_regs_tb;
    // ========================================================================
    // six-channel build, so the two top bits must stay unstored
    localparam int NCH = 6;
    localparam logic [7:0] CH_MASK = 8'h3F;
    // detect frequency select lives outside this bank; the bench's software keeps it on AC
    localparam logic [1:0] DETECT_FREQUENCY_SELECT = 2'h1;
    logic aclk;
    logic aresetn;
    logic ce;
    logic [7:0] s_axi_awaddr, s_axi_araddr, comp_pos_off, comp_neg_off, v;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    erl_pkg::erl_cfg_t cfg_q;
    erl_pkg::erl_cfg_t exp_cfg;
    logic [39:0] bq[$];
    logic [39:0] rq[$];
    int num_errors = 0;
    int tests_run = 0;
    int i;

    erl_regs #(.NUM_CHANNELS(NCH)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .comp_pos_off(comp_pos_off), .comp_neg_off(comp_neg_off), .cfg_q(cfg_q));

    // ========================================================================
    // clock at 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ========================================================================
    // compare, count and close
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // write: address and data offered together, bready held until bvalid is seen
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        bq.push_back({38'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    // read: the expected word is noted before the request goes out
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [7:0] d);
        rq.push_back({6'h0, r, 24'h0, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // ========================================================================
    // monitor: every response handshake takes the oldest note off its queue
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            check({38'h0, s_axi_bresp}, bq.size() ? bq.pop_front() : 40'hFFFFFFFFFF);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            check({6'h0, s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 40'hFF);
        end
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(3000 * 100);
        num_errors++;
        finish_test();
    end

    // ========================================================================
    // main sequence
    initial begin
        seed = 32'h24A2;
        aresetn = 1'b0;
        ce = 1'b1;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        comp_pos_off = 8'h00;
        comp_neg_off = 8'h00;
        exp_cfg = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check(cfg_q, exp_cfg);
        for (i = 0; i < 5; i++) axi_rd(8'(8'h34 + 4 * i), erl_pkg::RESP_OKAY, 8'h00);
        // random contents, absent channels dropped, read back at once
        repeat (4) begin
            for (i = 0; i < 5; i++) begin
                v = 8'($random(seed));
                axi_wr(8'(8'h34 + 4 * i), v, 4'hF, erl_pkg::RESP_OKAY);
                exp_cfg[8 * i +: 8] = v & CH_MASK;
                check(cfg_q, exp_cfg);
            end
            for (i = 0; i < 5; i++) axi_rd(8'(8'h34 + 4 * i), erl_pkg::RESP_OKAY, exp_cfg[8 * i +: 8]);
        end
        // walking one: bit n-1 lands on channel n only
        for (i = 0; i < 8; i++) begin
            axi_wr(8'h38, 8'(1 << i), 4'hF, erl_pkg::RESP_OKAY);
            exp_cfg.bias_negative_routing = 8'(1 << i) & CH_MASK;
            check(cfg_q, exp_cfg);
        end
        axi_wr(8'h38, 8'h2A, 4'hF, erl_pkg::RESP_OKAY);
        exp_cfg.bias_negative_routing = 8'h2A;
        // strobe off, status writes and unmapped places leave the bank alone
        axi_wr(8'h44, ~exp_cfg.leadoff_current_polarity, 4'h0, erl_pkg::RESP_OKAY);
        axi_wr(8'h48, 8'hFF, 4'hF, erl_pkg::RESP_OKAY);
        axi_wr(8'h4C, 8'hFF, 4'hF, erl_pkg::RESP_OKAY);
        check(cfg_q, exp_cfg);
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h30 : ((i == 1) ? 8'h50 : 8'hFC);
            axi_wr(v, 8'hFF, 4'hF, erl_pkg::RESP_SLVERR);
            axi_rd(v, erl_pkg::RESP_SLVERR, 8'h00);
            check(cfg_q, exp_cfg);
        end
        // off flags follow the comparators, absent channels masked; ce low with the bus idle
        repeat (4) begin
            @(posedge aclk);
            ce <= 1'b0;
            comp_pos_off <= 8'($random(seed));
            comp_neg_off <= 8'($random(seed));
            repeat (2) @(posedge aclk);
            ce <= 1'b1;
            axi_rd(8'h48, erl_pkg::RESP_OKAY, comp_pos_off & CH_MASK);
            axi_rd(8'h4C, erl_pkg::RESP_OKAY, comp_neg_off & CH_MASK);
        end
        // second reset in mid-run clears every register
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        exp_cfg = '0;
        @(posedge aclk);
        check(cfg_q, exp_cfg);
        for (i = 0; i < 5; i++) axi_rd(8'(8'h34 + 4 * i), erl_pkg::RESP_OKAY, 8'h00);
        repeat (4) @(posedge aclk);
        finish_test();
    end
endmodule
